// ---- rtl/pfp_frame_programmer.sv ----
// pfp_frame_programmer: timing chain, word multiplexer, output register,
// format control monitor and an AXI4-Lite register slave.
// assumes the converter and digital multiplexer answer on the system clock.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - serial output 64 kbit/s, 8-bit words, 160 words, 50 sub-frames per second
// - 500 sps channels ten times, 100 sps twice per sub-frame, evenly spaced
// - 50 sps every sub-frame, 10 sps every fifth, 1 sps once per frame
// - sub-frame holds 149 data, 3 sync, 1 sub-frame id, 7 spare words
// - converted 8-bit analog word loads output register, shifted at bit rate
// - digital slots load the digital multiplexer word instead
// - sync, test and id words pass through the digital multiplexer path
// - slow rate only slows output register; conversion keeps normal pace
// - slow sub-commutated group sits at words 18, 58, 98, 138
// - minimum mode sends only those four words at 1/40 speed, 1.6 kbit/s
// - minimum frame: 3 sync, mode id, twenty test words, 199 of 200 used
// - sync triple once per 200-word frame slow, once per sub-frame normal
// - 512 kHz base from internal oscillator or external pin, down to 1/s
// - external clock and 1/s reset normally; internal clock ignores reset
// - countdown in four sections; decoded states drive commutation and output
// - format request comes from ground command register or manual pin
// - one of two format control codes is inserted in the stream; the code inserts it in normal format only, not in the minimum frame
// - monitor at output register detects code; rate changes next frame
// - format selector gates loads and shifts of the output register
// - format switch only at end of a full sub-commutation cycle
// - serial data is NRZ
// - sync words carry a 23-of-24-bit pseudo-random pattern
// - alternate sub-frames use the complemented sync pattern
module pfp_frame_programmer
	import pfp_pkg::*;
#(
	parameter int ADDR_W = 4
)
(
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic EXT_CLK_I,
	input wire logic EXT_PPS_I,
	input wire logic MANUAL_MIN_I,
	input wire logic [7:0] ADC_DATA_I,
	input wire logic [7:0] DIG_DATA_I,
	output logic SER_DATA_O,
	output logic CONV_START_O,
	output logic [7:0] SLOT_WORD_O,
	output logic [5:0] SLOT_SUB_O,
	output logic DIG_SEL_O,
	output logic MIN_MODE_O,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// the register decode compares against 4-bit offsets
	if (ADDR_W < 3 || ADDR_W > 4)
		$error("ADDR_W must be 3 or 4");

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [2:0] ext_clk_q;
	logic [2:0] pps_q;
	logic [1:0] man_q;
	logic [1:0] ctrl_q;
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			ext_clk_q <= 3'h0;
			pps_q <= 3'h0;
			man_q <= 2'h0;
		end
		else
		begin
			ext_clk_q <= {ext_clk_q[1:0], EXT_CLK_I};
			pps_q <= {pps_q[1:0], EXT_PPS_I};
			man_q <= {man_q[0], MANUAL_MIN_I};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// base clock: internal oscillator as a phase accumulator, or external pin
	localparam logic [25:0] ACC_STEP = 26'(BASE_CLK_HZ);
	localparam logic [25:0] ACC_WRAP = 26'(SYS_CLK_HZ);
	logic [25:0] acc_q;
	wire [25:0] acc_sum = acc_q + ACC_STEP;
	wire int_tick = acc_sum >= ACC_WRAP;
	wire use_int = ctrl_q[CTRL_INT_BIT];
	wire ext_tick = ext_clk_q[1] & ~ext_clk_q[2];
	wire base_tick = use_int ? int_tick : ext_tick;
	// the 1/s reset is meaningless against the free internal clock
	wire pps_reset = ~use_int & pps_q[1] & ~pps_q[2];
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
			acc_q <= 26'h0;
		else
			acc_q <= int_tick ? acc_sum - ACC_WRAP : acc_sum;
	end

	////////////////////////////////////////////////////////////////////////////
	// four-section countdown: prescale, bit, word, sub-frame
	logic [2:0] pre_q;
	logic [2:0] bit_q;
	logic [7:0] word_q;
	logic [5:0] sub_q;
	wire bit_tick = base_tick && pre_q == 3'(PRESCALE - 1);
	wire word_end = bit_tick && bit_q == 3'(BITS_PER_WORD - 1);
	wire sub_end = word_end && word_q == 8'(WORDS_PER_SUB - 1);
	wire frame_end = sub_end && sub_q == 6'(SUBS_PER_FRAME - 1);
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I || pps_reset)
		begin
			pre_q <= 3'h0;
			bit_q <= 3'h0;
			word_q <= 8'h0;
			sub_q <= 6'h0;
		end
		else if (base_tick)
		begin
			pre_q <= bit_tick ? 3'h0 : pre_q + 3'h1;
			if (bit_tick)
				bit_q <= bit_q + 3'h1;
			if (word_end)
				word_q <= sub_end ? 8'h0 : word_q + 8'h1;
			if (sub_end)
				sub_q <= frame_end ? 6'h0 : sub_q + 6'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// slot decode for the word now being commutated and converted
	wire [7:0] a_rel = word_q - A_SLOT_FIRST;
	wire is_a_slot = word_q >= A_SLOT_FIRST && a_rel % A_SLOT_SPACING == 8'h0;
	wire [7:0] min_idx = 8'({sub_q, 2'h0} + 8'(a_rel / A_SLOT_SPACING));
	wire is_sync = word_q < 8'h3;
	wire is_dig = word_q[1:0] == DIG_SLOT_PHASE;
	wire is_test = word_q == TEST_SLOT_0 || word_q == TEST_SLOT_1 ||
		word_q == TEST_SLOT_2 || word_q == TEST_SLOT_3;
	wire fmt_req = ctrl_q[CTRL_MIN_BIT] | man_q[1];
	wire [7:0] fmt_code = fmt_req ? FMT_MIN_CODE : FMT_NORMAL_CODE;
	wire [23:0] sync_word = sub_q[0] ? ~SYNC_PATTERN : SYNC_PATTERN;
	wire [7:0] sync_byte = sync_word[8'(23) - {word_q[1:0], 3'h0} -: 8];
	wire [7:0] min_sync = SYNC_PATTERN[8'(23) - {min_idx[1:0], 3'h0} -: 8];
	wire min_test = min_idx >= MIN_TEST_FIRST && min_idx <= MIN_TEST_LAST;
	logic [7:0] slot_data;
	// internal words share the digital path; analog words come from the converter
	always_comb
	begin
		slot_data = ADC_DATA_I;
		if (is_sync)
			slot_data = sync_byte;
		else if (word_q == FRAME_ID_SLOT)
			slot_data = {2'h0, sub_q};
		else if (word_q == FORMAT_SLOT)
			slot_data = fmt_code;
		else if (is_test)
			slot_data = TEST_CODE;
		else if (is_dig)
			slot_data = DIG_DATA_I;
	end
	logic [7:0] min_data;
	// minimum frame fills the spare A-slot spaces with its own header and tests
	always_comb
	begin
		min_data = slot_data;
		if (min_idx < 8'h3)
			min_data = min_sync;
		else if (min_idx == MIN_MODE_ID_IDX)
			min_data = MODE_ID_CODE;
		else if (min_test)
			min_data = TEST_CODE ^ min_idx;
		else if (min_idx == MIN_SPARE_IDX)
			min_data = 8'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// format monitor and selector
	pfp_mode_type mode_q;
	pfp_mode_type pend_q;
	wire mode_min = mode_q == PFP_MINIMUM;
	// the new mode governs the first word of a new frame, which loads here
	wire frame_load = word_end && word_q == 8'h0 && sub_q == 6'h0;
	wire eff_min = frame_load ? pend_q == PFP_MINIMUM : mode_min;
	wire [7:0] load_data = eff_min ? min_data : slot_data;
	wire load_en = word_end && (!eff_min || is_a_slot);
	logic [5:0] min_div_q;
	wire min_step = bit_tick && min_div_q == 6'(MIN_DIVIDE - 1);
	wire shift_en = !load_en && (mode_min ? min_step : bit_tick);
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			mode_q <= PFP_NORMAL;
			pend_q <= PFP_NORMAL;
		end
		else
		begin
			if (word_end && word_q == FORMAT_SLOT)
				pend_q <= slot_data == FMT_MIN_CODE ? PFP_MINIMUM : PFP_NORMAL;
			if (frame_load)
				mode_q <= pend_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output register, MSB first as NRZ-L
	logic [7:0] shift_q;
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			shift_q <= 8'h0;
			min_div_q <= 6'h0;
		end
		else
		begin
			if (load_en)
				shift_q <= load_data;
			else if (shift_en)
				shift_q <= {shift_q[6:0], 1'b0};
			if (load_en || min_step)
				min_div_q <= 6'h0;
			else if (bit_tick)
				min_div_q <= min_div_q + 6'h1;
		end
	end
	assign SER_DATA_O = shift_q[7];

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			CONV_START_O <= 1'b0;
			SLOT_WORD_O <= 8'h0;
			SLOT_SUB_O <= 6'h0;
			DIG_SEL_O <= 1'b0;
			MIN_MODE_O <= 1'b0;
		end
		else
		begin
			// conversion pace is the same in both formats
			CONV_START_O <= bit_tick && bit_q == 3'h0;
			SLOT_WORD_O <= word_q;
			SLOT_SUB_O <= sub_q;
			DIG_SEL_O <= is_dig;
			MIN_MODE_O <= mode_min;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: address and data taken in either order
	logic aw_have_q;
	logic w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic wstrb0_q;
	wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_take = S_AXI_WVALID && S_AXI_WREADY;
	wire wr_go = aw_have_q && w_have_q && !S_AXI_BVALID;
	wire wr_ctrl = awaddr_q[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2];
	wire wr_stat = awaddr_q[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2];
	wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
	wire rd_ctrl = S_AXI_ARADDR[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2];
	wire rd_stat = S_AXI_ARADDR[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2];
	wire [31:0] stat_word = (32'(mode_min) << STAT_MODE_BIT) |
		(32'(pend_q == PFP_MINIMUM) << STAT_PEND_BIT) |
		(32'(word_q) << STAT_WORD_LSB) | (32'(sub_q) << STAT_SUB_LSB);
	wire [31:0] rd_word = rd_ctrl ? {30'h0, ctrl_q} : (rd_stat ? stat_word : 32'h0);
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb0_q <= 1'b0;
			ctrl_q <= CTRL_RESET;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end
		else
		begin
			// ready mirrors the next holding state, so it stays a register
			S_AXI_AWREADY <= wr_go || !(aw_have_q || aw_take);
			S_AXI_WREADY <= wr_go || !(w_have_q || w_take);
			if (aw_take)
			begin
				aw_have_q <= 1'b1;
				awaddr_q <= S_AXI_AWADDR;
			end
			if (w_take)
			begin
				w_have_q <= 1'b1;
				wdata_q <= S_AXI_WDATA;
				wstrb0_q <= S_AXI_WSTRB[0];
			end
			if (wr_go)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (wr_ctrl || wr_stat) ? RESP_OKAY : RESP_SLVERR;
				if (wr_ctrl && wstrb0_q)
					ctrl_q <= wdata_q[1:0];
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= RESP_OKAY;
			S_AXI_ARREADY <= 1'b0;
		end
		else
		begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !ar_take && !S_AXI_ARREADY;
			if (ar_take)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_word;
				S_AXI_RRESP <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	count_range_a: assert property (word_q < 8'd160 && sub_q < 6'd50)
		else $error("slot counters out of range");
	word_wrap_a: assert property (sub_end |=> word_q == 8'h0)
		else $error("word counter did not wrap at end of sub-frame");
	sequence normal_sync_load;
		load_en && !eff_min && word_q == 8'h0;
	endsequence
	sync_alt_a: assert property (normal_sync_load |=>
		shift_q == ($past(sub_q[0]) ? ~SYNC_PATTERN[23:16] : SYNC_PATTERN[23:16]))
		else $error("first sync word wrong for sub-frame parity");
	dig_slot_a: assert property (load_en && !eff_min && word_q == 8'h3
		|=> shift_q == $past(DIG_DATA_I))
		else $error("digital slot did not load digital word");
	min_load_a: assert property (load_en && eff_min |-> is_a_slot)
		else $error("minimum mode loaded a non-A word");
	min_rate_a: assert property (shift_en && mode_min |-> min_div_q == 6'd39)
		else $error("minimum mode shift not at 1/40 rate");
	switch_edge_a: assert property ($changed(mode_q) |-> $past(frame_load))
		else $error("format changed outside frame boundary");
	fmt_word_a: assert property (word_q == FORMAT_SLOT && !is_sync
		|-> slot_data == (fmt_req ? FMT_MIN_CODE : FMT_NORMAL_CODE))
		else $error("format control word not inserted");
	reset_state_a: assert property ($fell(RST_I) |-> !mode_min && word_q == 8'h0)
		else $error("reset did not start normal format at word one");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped before ready");
endmodule

// ---- rtl/pfp_pkg.sv ----
// pfp_pkg: constants for the telemetry frame programmer.
// assumes a 50 MHz system clock and one AXI4-Lite master.
package pfp_pkg;
	localparam int SYS_CLK_HZ = 50_000_000;
	localparam int BASE_CLK_HZ = 512_000;
	localparam int BIT_RATE_BPS = 64_000;
	// base ticks per output bit, derived from the two rates
	localparam int PRESCALE = BASE_CLK_HZ / BIT_RATE_BPS;
	localparam int BITS_PER_WORD = 8;
	localparam int WORDS_PER_SUB = 160;
	localparam int SUBS_PER_FRAME = 50;
	localparam int SUBCOM_SLOW = 5;
	localparam int MIN_DIVIDE = 40;
	localparam logic [7:0] A_SLOT_FIRST = 8'h11;
	localparam logic [7:0] A_SLOT_SPACING = 8'h28;
	localparam logic [7:0] FRAME_ID_SLOT = 8'h20;
	localparam logic [7:0] FORMAT_SLOT = 8'h79;
	localparam logic [7:0] TEST_SLOT_0 = 8'h08;
	localparam logic [7:0] TEST_SLOT_1 = 8'h50;
	localparam logic [7:0] TEST_SLOT_2 = 8'h58;
	localparam logic [7:0] TEST_SLOT_3 = 8'h60;
	localparam logic [1:0] DIG_SLOT_PHASE = 2'h3;
	localparam logic [7:0] MIN_MODE_ID_IDX = 8'h03;
	localparam logic [7:0] MIN_TEST_FIRST = 8'h04;
	localparam logic [7:0] MIN_TEST_LAST = 8'h17;
	localparam logic [7:0] MIN_SPARE_IDX = 8'hc7;
	localparam logic [23:0] SYNC_PATTERN = 24'hf1a46e;
	localparam logic [7:0] FMT_NORMAL_CODE = 8'h3c;
	localparam logic [7:0] FMT_MIN_CODE = 8'hc3;
	localparam logic [7:0] MODE_ID_CODE = 8'ha5;
	localparam logic [7:0] TEST_CODE = 8'h5a;
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam int CTRL_MIN_BIT = 0;
	localparam int CTRL_INT_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int STAT_MODE_BIT = 0;
	localparam int STAT_PEND_BIT = 1;
	localparam int STAT_WORD_LSB = 8;
	localparam int STAT_SUB_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic {PFP_NORMAL, PFP_MINIMUM} pfp_mode_type;
endpackage

// ---- testbench/pfp_ground_rx.sv ----
// pfp_ground_rx: ground station model, bit sync and sync search on the serial line.
// assumes a 32-cycle bit time, i.e. the base clock pin toggles every two system cycles.
`timescale 1ns/1ps
module pfp_ground_rx
	import pfp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ser_i,
	output logic hit_o,
	output logic hit_inv_o,
	output logic [15:0] gap_o,
	output logic word_o,
	output logic [7:0] word_idx_o,
	output logic [7:0] word_val_o
);
	logic last = 1'b0;
	logic lock = 1'b0;
	logic [4:0] ph = 5'h00;
	logic [23:0] sh = 24'h000000;
	logic [15:0] gap = 16'h0000;
	logic [7:0] idx = 8'h00;
	logic [2:0] nb = 3'h0;
	////////////////////////////////////////////////////////////////////////////////
	// bit clock recovered from transitions; long runs coast on the free counter
	always @(posedge clk_i)
	begin
		hit_o <= 1'b0;
		word_o <= 1'b0;
		if (ser_i !== last)
			ph = 5'h00;
		else
			ph = ph + 5'h01;
		last = ser_i;
		if (rst_i)
			lock = 1'b0;
		else if (ph == 5'h0f)
		begin
			sh = {sh[22:0], ser_i};
			gap = gap + 16'h0001;
			nb = nb + 3'h1;
			if (sh == SYNC_PATTERN || sh == ~SYNC_PATTERN)
			begin
				hit_o <= 1'b1;
				hit_inv_o <= (sh != SYNC_PATTERN);
				gap_o <= gap;
				gap = 16'h0000;
				nb = 3'h0;
				idx = 8'h03;
				lock = 1'b1;
			end
			else if (lock && nb == 3'h0)
			begin
				word_o <= 1'b1;
				word_idx_o <= idx;
				word_val_o <= sh[7:0];
				idx = idx + 8'h01;
			end
		end
	end
endmodule

// ---- testbench/tb_top.sv ----
// tb_top: drives the frame programmer from a fast base clock and checks the serial stream.
// assumes the base clock pin may run far above 512 kHz so two sub-frames fit the run.
`timescale 1ns/1ps
module tb_top
	import pfp_pkg::*;
;
	logic CLOCK_I = 1'b0, RST_I = 1'b1, EXT_CLK_I = 1'b0, MANUAL_MIN_I = 1'b0;
	logic [7:0] ADC_DATA_I = 8'h00, DIG_DATA_I = 8'h00, SLOT_WORD_O;
	logic SER_DATA_O, CONV_START_O, DIG_SEL_O, MIN_MODE_O;
	logic [5:0] SLOT_SUB_O;
	logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'h0;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic [31:0] S_AXI_WDATA = 32'h00000000, S_AXI_RDATA, r;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic hit, hit_inv, word, first = 1'b1;
	logic [15:0] gap;
	logic [7:0] word_idx, word_val;
	logic [7:0] exp_q[$];
	int fails = 0, samples_checked = 0, conv_cnt = 0, n;
	integer seed = 32'h029e;
	always #10 CLOCK_I = ~CLOCK_I;
	// base ticks every 4 cycles: a word slot is 256 cycles, a sub-frame 40960
	always #40 EXT_CLK_I = ~EXT_CLK_I;
	pfp_frame_programmer DUT (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .EXT_CLK_I(EXT_CLK_I),
		.EXT_PPS_I(1'b0), .MANUAL_MIN_I(MANUAL_MIN_I), .ADC_DATA_I(ADC_DATA_I),
		.DIG_DATA_I(DIG_DATA_I), .SER_DATA_O(SER_DATA_O), .CONV_START_O(CONV_START_O),
		.SLOT_WORD_O(SLOT_WORD_O), .SLOT_SUB_O(SLOT_SUB_O), .DIG_SEL_O(DIG_SEL_O),
		.MIN_MODE_O(MIN_MODE_O), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY));
	pfp_ground_rx rx (.clk_i(CLOCK_I), .rst_i(RST_I), .ser_i(SER_DATA_O), .hit_o(hit),
		.hit_inv_o(hit_inv), .gap_o(gap), .word_o(word), .word_idx_o(word_idx),
		.word_val_o(word_val));
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("counts: samples_checked=%0d fails=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_up(input logic ok);
		if (!ok)
		begin
			fails++;
			finish_test();
		end
	endtask
	task automatic pop(input logic [7:0] seen);
		logic [7:0] e;
		e = (exp_q.size() > 0) ? exp_q.pop_front() : ~seen;
		check({24'h000000, seen}, {24'h000000, e});
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] rs);
		int k;
		logic ta, tw, tb;
		logic [1:0] rv;
		@(posedge CLOCK_I);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		tb = 1'b0;
		for (k = 0; k < 100 && !tb; k++)
		begin
			@(negedge CLOCK_I);
			ta = ta | (S_AXI_AWVALID & S_AXI_AWREADY);
			tw = tw | (S_AXI_WVALID & S_AXI_WREADY);
			tb = S_AXI_BVALID & S_AXI_BREADY;
			rv = S_AXI_BRESP;
			@(posedge CLOCK_I);
			if (ta)
				S_AXI_AWVALID <= 1'b0;
			if (tw)
				S_AXI_WVALID <= 1'b0;
			if (tb)
				S_AXI_BREADY <= 1'b0;
		end
		give_up(tb);
		check({30'h0, rv}, {30'h0, rs});
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rs,
		input logic [31:0] m);
		int k;
		logic ta, tr;
		logic [31:0] dv;
		logic [1:0] rv;
		@(posedge CLOCK_I);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		tr = 1'b0;
		for (k = 0; k < 100 && !tr; k++)
		begin
			@(negedge CLOCK_I);
			ta = S_AXI_ARVALID & S_AXI_ARREADY;
			tr = S_AXI_RVALID & S_AXI_RREADY;
			dv = S_AXI_RDATA;
			rv = S_AXI_RRESP;
			@(posedge CLOCK_I);
			if (ta)
				S_AXI_ARVALID <= 1'b0;
			if (tr)
				S_AXI_RREADY <= 1'b0;
		end
		give_up(tr);
		check(dv & m, d);
		check({30'h0, rv}, {30'h0, rs});
	endtask
	task automatic wait_slot(input logic [5:0] s, input logic [7:0] w);
		int k;
		for (k = 0; k < 60000 && !(SLOT_SUB_O === s && SLOT_WORD_O === w); k++)
			@(posedge CLOCK_I);
		give_up(k < 60000);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// result watcher: every sync hit and selected word takes the oldest note
	always @(posedge CLOCK_I)
	begin
		if (hit === 1'b1)
		begin
			pop({7'h00, hit_inv});
			if (!first)
				check({16'h0000, gap}, 32'h00000500);
			first = 1'b0;
		end
		if (word === 1'b1 && word_idx == 8'h03)
			pop(word_val);
		if (word === 1'b1 && word_idx == 8'h04)
			pop(word_val);
		if (word === 1'b1 && word_idx == FORMAT_SLOT)
			pop(word_val);
		if (CONV_START_O === 1'b1)
		begin
			check({31'h0, DIG_SEL_O}, {31'h0, SLOT_WORD_O[1:0] == DIG_SLOT_PHASE});
			if (conv_cnt != 0)
				check(conv_cnt, 32'h00000100);
			conv_cnt = 1;
		end
		else if (conv_cnt != 0)
			conv_cnt = conv_cnt + 1;
	end
	initial
	begin
		r = $random(seed);
		DIG_DATA_I <= r[7:0];
		ADC_DATA_I <= r[15:8];
		exp_q = '{8'h00, r[7:0], r[15:8], FMT_NORMAL_CODE};
		repeat (4) @(posedge CLOCK_I);
		check({21'h0, SLOT_WORD_O, 1'b0, MIN_MODE_O, SER_DATA_O}, 32'h0);
		RST_I <= 1'b0;
		axi_rd(CTRL_OFFSET, 32'h0, RESP_OKAY, 32'hffffffff);
		axi_wr(CTRL_OFFSET, {r[31:2], 2'h1}, 4'hf, RESP_OKAY);
		axi_wr(CTRL_OFFSET, 32'h0, 4'he, RESP_OKAY);
		axi_rd(CTRL_OFFSET, 32'h1, RESP_OKAY, 32'hffffffff);
		axi_wr(CTRL_OFFSET, 32'h0, 4'hf, RESP_OKAY);
		axi_wr(STATUS_OFFSET, 32'h3, 4'hf, RESP_OKAY);
		axi_rd(STATUS_OFFSET, 32'h0, RESP_OKAY, 32'h3);
		axi_wr(4'h8, 32'h0, 4'hf, RESP_SLVERR);
		axi_rd(4'hc, 32'h0, RESP_SLVERR, 32'hffffffff);
		$display("test registers done");
		wait_slot(6'h00, 8'h82);
		axi_rd(STATUS_OFFSET, 32'h0, RESP_OKAY, 32'h3);
		@(posedge CLOCK_I);
		MANUAL_MIN_I <= 1'b1;
		exp_q.push_back(8'h01);
		exp_q.push_back(r[7:0]);
		exp_q.push_back(r[15:8]);
		exp_q.push_back(FMT_MIN_CODE);
		$display("test normal sub-frame done");
		wait_slot(6'h01, 8'h7e);
		// minimum request seen, but the switch must wait for the next frame boundary
		axi_rd(STATUS_OFFSET, 32'h2, RESP_OKAY, 32'h3);
		check({31'h0, MIN_MODE_O}, 32'h0);
		for (n = 0; n < 2000 && exp_q.size() > 0; n++)
			@(posedge CLOCK_I);
		check(exp_q.size(), 32'h0);
		$display("test manual request done");
		finish_test();
	end
endmodule
